// [ncx_consts.vh]
/*
 * Shared constants of the nibble core execution unit: operation codes,
 * register pair indices and reset values.
 * Assumes it is included by bare name into the design file.
 */
`ifndef NCX_CONSTS_VH
`define NCX_CONSTS_VH

// ************************************************************
// Operation codes presented on op_code_in
// ************************************************************
`define NCX_OP_TF_PCDE   4'h0
`define NCX_OP_TF_PCXA   4'h1
`define NCX_OP_TF_BCDE   4'h2
`define NCX_OP_TF_BCXA   4'h3
`define NCX_OP_BIT_LD    4'h4
`define NCX_OP_BIT_ST    4'h5
`define NCX_OP_ADDS_N4   4'h6
`define NCX_OP_ADDS_N8   4'h7
`define NCX_OP_ADDS_XARP 4'h8
`define NCX_OP_ADDS_RPXA 4'h9
`define NCX_OP_ADDS_MEM  4'hA
`define NCX_OP_ADD_CARRY_INSN_MEM  4'hB
`define NCX_OP_ADD_CARRY_INSN_XARP 4'hC
`define NCX_OP_ADD_CARRY_INSN_RPXA 4'hD
`define NCX_OP_SUB_SKIP_INSN_MEM  4'hE
`define NCX_OP_SUB_SKIP_INSN_XARP 4'hF

// ************************************************************
// Register pair indices (high nibble first: X/H/D/B)
// ************************************************************
`define NCX_PAIR_XA      3'h0
`define NCX_PAIR_HL      3'h1
`define NCX_PAIR_DE      3'h2
`define NCX_PAIR_BC      3'h3
`define NCX_PAIR_CNT     8

// ************************************************************
// Field positions and reset values
// ************************************************************
`define NCX_PC_PAGE_HI   15
`define NCX_PC_PAGE_LO   8
`define NCX_RST_PAIR     8'h00
`define NCX_RST_BIT      1'b0
`define NCX_RST_PADDR    16'h0000
`define NCX_RST_DADDR    8'h00
`define NCX_RST_NIB      4'h0

`endif

// [ncx_exec_core.v]
/*
 * Execution unit of a 4-bit core for table fetches, single-bit moves
 * and add/subtract operations, with its register file and carry flag.
 * Assumes one decoded operation at a time while ready_out is high,
 * a program memory and a data memory that answer one cycle after
 * their read strobe, and a sequencer that advances the program counter.
 */
`timescale 1ns/10ps
`include "ncx_consts.vh"

// Overview of operation
// - DE table fetch: PC page with DE as low byte; low to A, high to X.
// - XA table fetch: PC page with XA as low byte; low to A, high to X.
// - Table fetches never change the program counter.
// - Page comes from the PC in effect at execution, next page at xxFF.
// - BCDE table fetch: address B,C,D,E; low nibble to A, high to X.
// - BCXA table fetch: address B,C,X,A; low nibble to A, high to X.
// - Bit load copies the selected data memory bit into the carry.
// - Bit store writes the carry into the selected data memory bit.
// - Nibble immediate add into A; carry skips next; carry unchanged.
// - Byte immediate add into acc pair; carry skips next; carry kept.
// - Pair adds into acc pair or other pair; carry skips; carry kept.
// - Memory nibble add into A; carry skips next; carry unchanged.
// - Memory add with carry into A; carry set on carry else cleared.
// - Nibble add after memory add-carry: skipped on carry, else no skip.
// - Pair add with carry into acc pair or other pair; updates carry.
// - Memory nibble subtract from A; borrow skips next; carry kept.
// - Pair subtract from acc pair; borrow skips next; carry kept.
module ncx_exec_core (
  // Clock and reset.
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  // Decoded operation.
  input  wire        op_valid_in,
  input  wire [3:0]  op_code_in,
  input  wire [2:0]  op_pair_in,
  input  wire [7:0]  op_imm_in,
  input  wire [15:0] op_pc_in,
  input  wire [7:0]  bit_addr_in,
  input  wire [1:0]  bit_pos_in,
  // Operation status.
  output wire        ready_out,
  output wire        done_out,
  output wire        skip_out,
  output wire        carry_out,
  output wire [63:0] regs_out,
  // Program memory.
  output wire [15:0] pmem_addr_out,
  output wire        pmem_rd_out,
  input  wire [7:0]  pmem_data_in,
  // Data memory.
  output wire [7:0]  dmem_addr_out,
  output wire        dmem_rd_out,
  output wire        dmem_we_out,
  output wire [3:0]  dmem_wdata_out,
  input  wire [3:0]  dmem_data_in
);

  // ************************************************************
  // State encoding
  // ************************************************************
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_PWAIT  = 3'h1;
  localparam [2:0] S_PDATA  = 3'h2;
  localparam [2:0] S_DWAIT  = 3'h3;
  localparam [2:0] S_DDATA  = 3'h4;

  // ************************************************************
  // Storage
  // ************************************************************
  // Register file: each pair keeps its high nibble in [7:4].
  reg [7:0]  pair_r [0:`NCX_PAIR_CNT-1];
  // Sequencer state and the operation latched while memory answers.
  reg [2:0]  state_r;
  reg [3:0]  op_r;
  reg [1:0]  bpos_r;
  // Flags: carry, pending skip and the decimal adjust window.
  reg        cy_r;
  reg        skip_r;
  reg        adj_r;
  reg        adj_cy_r;
  reg        ready_r;
  reg        done_r;
  // Memory strobes, addresses and write data, each held in a flip-flop.
  reg [15:0] paddr_r;
  reg        prd_r;
  reg [7:0]  daddr_r;
  reg        drd_r;
  reg        dwe_r;
  reg [3:0]  dwdata_r;
  integer    i;

  // ************************************************************
  // Operand selection and arithmetic
  // ************************************************************
  // Operands come from the inputs while idle and from the latched
  // operation once the data memory has answered.
  wire [7:0] xa_w   = pair_r[`NCX_PAIR_XA];
  wire [7:0] rp_w   = pair_r[op_pair_in];
  wire       dphase = (state_r == S_DDATA);
  wire       is_n8  = (op_code_in == `NCX_OP_ADDS_N8);
  wire       is_c8  = (op_code_in == `NCX_OP_ADD_CARRY_INSN_XARP) |
                      (op_code_in == `NCX_OP_ADD_CARRY_INSN_RPXA);
  wire [7:0] opnd8  = is_n8 ? op_imm_in : rp_w;
  wire [8:0] sum8   = {1'b0, xa_w} + {1'b0, opnd8} + {8'h00, is_c8 & cy_r};
  wire [8:0] dif8   = {1'b0, xa_w} - {1'b0, rp_w};
  wire       cin4   = dphase & (op_r == `NCX_OP_ADD_CARRY_INSN_MEM) & cy_r;
  wire [3:0] opnd4  = dphase ? dmem_data_in : op_imm_in[3:0];
  wire [4:0] sum4   = {1'b0, xa_w[3:0]} + {1'b0, opnd4} + {4'h0, cin4};
  wire [4:0] dif4   = {1'b0, xa_w[3:0]} - {1'b0, dmem_data_in};
  // Bit store: clear the selected bit, then place the carry there.
  wire [3:0] bmask  = 4'h1 << bpos_r;
  wire [3:0] bset   = {3'h0, cy_r} << bpos_r;

  // Table address; the page is taken from the PC in effect while the
  // fetch executes, so a fetch at the last byte of a page reads the next.
  reg [15:0] taddr_w;
  always @* begin
    case (op_code_in[1:0])
      2'h0:    taddr_w = {op_pc_in[`NCX_PC_PAGE_HI:`NCX_PC_PAGE_LO],
                          pair_r[`NCX_PAIR_DE]};
      2'h1:    taddr_w = {op_pc_in[`NCX_PC_PAGE_HI:`NCX_PC_PAGE_LO],
                          xa_w};
      2'h2:    taddr_w = {pair_r[`NCX_PAIR_BC],
                          pair_r[`NCX_PAIR_DE]};
      default: taddr_w = {pair_r[`NCX_PAIR_BC], xa_w};
    endcase
  end

  // ************************************************************
  // Sequencer and datapath
  // ************************************************************
  // Strobes and done are one-cycle pulses cleared by default. The core
  // drives no program counter, so a table fetch leaves it alone.
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      for (i = 0; i < `NCX_PAIR_CNT; i = i + 1) begin
        pair_r[i] <= `NCX_RST_PAIR;
      end
      state_r  <= S_IDLE;
      op_r     <= `NCX_RST_NIB;
      bpos_r   <= 2'h0;
      cy_r     <= `NCX_RST_BIT;
      skip_r   <= `NCX_RST_BIT;
      adj_r    <= `NCX_RST_BIT;
      adj_cy_r <= `NCX_RST_BIT;
      ready_r  <= 1'b1;
      done_r   <= 1'b0;
      paddr_r  <= `NCX_RST_PADDR;
      prd_r    <= 1'b0;
      daddr_r  <= `NCX_RST_DADDR;
      drd_r    <= 1'b0;
      dwe_r    <= 1'b0;
      dwdata_r <= `NCX_RST_NIB;
    end else begin
      done_r <= 1'b0;
      prd_r  <= 1'b0;
      drd_r  <= 1'b0;
      dwe_r  <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (op_valid_in && ready_r) begin
            op_r   <= op_code_in;
            adj_r  <= 1'b0;
            // A pending skip consumes this op; it touches no register or memory.
            // A nibble add right after a carried memory add-carry is dropped too.
            if (skip_r) begin
              skip_r <= 1'b0;
              done_r <= 1'b1;
            end else if (adj_r && adj_cy_r &&
                         op_code_in == `NCX_OP_ADDS_N4) begin
              done_r <= 1'b1;
            end else begin
              case (op_code_in)
                // Table fetches latch the address now; the byte lands two cycles later.
                `NCX_OP_TF_PCDE, `NCX_OP_TF_PCXA,
                `NCX_OP_TF_BCDE, `NCX_OP_TF_BCXA: begin
                  paddr_r <= taddr_w;
                  prd_r   <= 1'b1;
                  ready_r <= 1'b0;
                  state_r <= S_PWAIT;
                end
                `NCX_OP_BIT_LD, `NCX_OP_BIT_ST: begin
                  daddr_r <= bit_addr_in;
                  bpos_r  <= bit_pos_in;
                  drd_r   <= 1'b1;
                  ready_r <= 1'b0;
                  state_r <= S_DWAIT;
                end
                `NCX_OP_ADDS_MEM, `NCX_OP_ADD_CARRY_INSN_MEM,
                `NCX_OP_SUB_SKIP_INSN_MEM: begin
                  daddr_r <= pair_r[`NCX_PAIR_HL];
                  drd_r   <= 1'b1;
                  ready_r <= 1'b0;
                  state_r <= S_DWAIT;
                end
                `NCX_OP_ADDS_N4: begin
                  pair_r[`NCX_PAIR_XA][3:0] <= sum4[3:0];
                  // After a carry-free memory add-carry the skip is disabled.
                  skip_r <= sum4[4] & ~adj_r;
                  done_r <= 1'b1;
                end
                // Byte adds share one 9-bit adder; bit 8 is the carry out of bit 7.
                `NCX_OP_ADDS_N8, `NCX_OP_ADDS_XARP: begin
                  pair_r[`NCX_PAIR_XA] <= sum8[7:0];
                  skip_r <= sum8[8];
                  done_r <= 1'b1;
                end
                `NCX_OP_ADDS_RPXA: begin
                  pair_r[op_pair_in] <= sum8[7:0];
                  skip_r <= sum8[8];
                  done_r <= 1'b1;
                end
                // Apart from bit load, only the add-with-carry forms write the carry flag.
                `NCX_OP_ADD_CARRY_INSN_XARP: begin
                  pair_r[`NCX_PAIR_XA] <= sum8[7:0];
                  cy_r   <= sum8[8];
                  done_r <= 1'b1;
                end
                `NCX_OP_ADD_CARRY_INSN_RPXA: begin
                  pair_r[op_pair_in] <= sum8[7:0];
                  cy_r   <= sum8[8];
                  done_r <= 1'b1;
                end
                // The only code left is the pair subtract from the acc pair.
                default: begin
                  pair_r[`NCX_PAIR_XA] <= dif8[7:0];
                  skip_r <= dif8[8];
                  done_r <= 1'b1;
                end
              endcase
            end
          end
        end
        // One wait cycle while the program memory answers its strobe.
        S_PWAIT: begin
          state_r <= S_PDATA;
        end
        S_PDATA: begin
          // Low nibble to A, high nibble to X in one write.
          pair_r[`NCX_PAIR_XA] <= pmem_data_in;
          done_r  <= 1'b1;
          ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
        // One wait cycle while the data memory answers its strobe.
        S_DWAIT: begin
          state_r <= S_DDATA;
        end
        S_DDATA: begin
          done_r  <= 1'b1;
          ready_r <= 1'b1;
          state_r <= S_IDLE;
          case (op_r)
            `NCX_OP_BIT_LD: begin
              cy_r <= dmem_data_in[bpos_r];
            end
            `NCX_OP_BIT_ST: begin
              // Read-modify-write keeps the other three bits intact.
              dwdata_r <= (dmem_data_in & ~bmask) | bset;
              dwe_r    <= 1'b1;
            end
            `NCX_OP_ADDS_MEM: begin
              pair_r[`NCX_PAIR_XA][3:0] <= sum4[3:0];
              skip_r <= sum4[4];
            end
            `NCX_OP_ADD_CARRY_INSN_MEM: begin
              pair_r[`NCX_PAIR_XA][3:0] <= sum4[3:0];
              cy_r     <= sum4[4];
              adj_r    <= 1'b1;
              adj_cy_r <= sum4[4];
            end
            default: begin
              pair_r[`NCX_PAIR_XA][3:0] <= dif4[3:0];
              skip_r <= dif4[4];
            end
          endcase
        end
        // Unused state codes fall back to idle, so the core cannot lock up.
        default: begin
          ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Outputs, all straight from flip-flops
  // ************************************************************
  assign ready_out      = ready_r;
  assign done_out       = done_r;
  assign skip_out       = skip_r;
  assign carry_out      = cy_r;
  assign regs_out       = {pair_r[7], pair_r[6], pair_r[5], pair_r[4],
                           pair_r[3], pair_r[2], pair_r[1], pair_r[0]};
  assign pmem_addr_out  = paddr_r;
  assign pmem_rd_out    = prd_r;
  assign dmem_addr_out  = daddr_r;
  assign dmem_rd_out    = drd_r;
  assign dmem_we_out    = dwe_r;
  assign dmem_wdata_out = dwdata_r;

endmodule // ncx_exec_core

// [ncx_mem_model.sv]
/* Program and data memory model facing the execution core.
   Assumes one-cycle strobes and data wanted in the cycle after. */
`timescale 1ns/10ps
module ncx_mem_model (
  // Clock.
  input  wire        clk_in,
  // Program memory.
  input  wire [15:0] paddr_in,
  input  wire        prd_in,
  output reg  [7:0]  pdata_out,
  // Data memory.
  input  wire [7:0]  daddr_in,
  input  wire        drd_in,
  input  wire        dwe_in,
  input  wire [3:0]  dwdata_in,
  output reg  [3:0]  ddata_out
);
  reg     [3:0] ram [0:255];
  integer       i;
  // Table bytes mix both address bytes, so a wrong page shows.
  function [7:0] rom(input [15:0] a);
    rom = a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
  endfunction
  initial begin
    pdata_out = 8'h00;
    ddata_out = 4'h0;
    for (i = 0; i < 256; i = i + 1)
      ram[i] = i[3:0] ^ 4'h9;
  end
  // Outside the answer cycle the buses toggle, so stale data never passes.
  always @(posedge clk_in) begin
    pdata_out <= prd_in ? rom(paddr_in) : ~pdata_out;
    ddata_out <= drd_in ? ram[daddr_in] : ~ddata_out;
    if (dwe_in)
      ram[daddr_in] <= dwdata_in;
  end
endmodule // ncx_mem_model

// [ncx_monitor.sv]
/* Checker of the execution core ports, bound to every core instance.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`include "ncx_consts.vh"
module ncx_monitor (
  // Clock, reset and operation port.
  input wire        sys_clk_in,
  input wire        reset_n_in,
  input wire        op_valid_in,
  input wire [3:0]  op_code_in,
  input wire [15:0] op_pc_in,
  input wire [1:0]  bit_pos_in,
  // Status and memories.
  input wire        ready_out,
  input wire        done_out,
  input wire        skip_out,
  input wire        carry_out,
  input wire [63:0] regs_out,
  input wire [15:0] pmem_addr_out,
  input wire        pmem_rd_out,
  input wire [7:0]  pmem_data_in,
  input wire [7:0]  dmem_addr_out,
  input wire        dmem_rd_out,
  input wire        dmem_we_out,
  input wire [3:0]  dmem_wdata_out,
  input wire [3:0]  dmem_data_in
);
  reg  [3:0] code_r;
  reg  [7:0] page_r;
  reg  [1:0] pos_r;
  reg        skp_r;
  reg  [3:0] dq_r;
  wire       take = op_valid_in && ready_out;
  // Remember the taken operation so that later outputs can be tied to it.
  always @(posedge sys_clk_in) begin
    dq_r <= dmem_data_in;
    if (!reset_n_in) begin
      code_r <= 4'h0;
      page_r <= 8'h00;
      pos_r <= 2'h0;
      skp_r <= 1'b0;
    end else if (take) begin
      code_r <= op_code_in;
      page_r <= op_pc_in[15:8];
      pos_r <= bit_pos_in;
      skp_r <= skip_out;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // A consumed op ends at once and leaves every register and the carry alone.
  a_skip_quick: assert property (take && skip_out |=> done_out)
    else $error("skipped op did not end at once");
  a_skip_inert: assert property (done_out && skp_r |->
    $stable(regs_out) && $stable(carry_out))
    else $error("skipped op changed state");
  // Table fetch: strobe, one wait cycle, then the byte in the acc pair.
  a_fetch_steps: assert property (take && !skip_out &&
    op_code_in <= `NCX_OP_TF_BCXA |=> pmem_rd_out ##1 !pmem_rd_out ##1 done_out)
    else $error("table fetch sequence wrong");
  a_table_page: assert property (pmem_rd_out &&
    code_r inside {`NCX_OP_TF_PCDE, `NCX_OP_TF_PCXA} |-> pmem_addr_out[15:8] == page_r)
    else $error("table page wrong");
  a_table_split: assert property (done_out && !skp_r && code_r <= `NCX_OP_TF_BCXA
    |-> regs_out[7:0] == $past(pmem_data_in))
    else $error("table byte not split into acc pair");
  // Memory ops read once and finish three cycles later; the nibble ops read at the HL address.
  a_mem_latency: assert property (take && !skip_out &&
    op_code_in inside {`NCX_OP_BIT_LD, `NCX_OP_BIT_ST, `NCX_OP_ADDS_MEM,
    `NCX_OP_ADD_CARRY_INSN_MEM, `NCX_OP_SUB_SKIP_INSN_MEM} |-> ##3 done_out)
    else $error("memory op latency wrong");
  a_hl_read: assert property (take && !skip_out &&
    op_code_in inside {`NCX_OP_ADDS_MEM, `NCX_OP_ADD_CARRY_INSN_MEM, `NCX_OP_SUB_SKIP_INSN_MEM} |=>
    dmem_rd_out && !ready_out && dmem_addr_out == $past(regs_out[15:8]))
    else $error("memory nibble read wrong");
  a_carry_kept: assert property (done_out &&
    code_r inside {[`NCX_OP_ADDS_N4:`NCX_OP_ADDS_MEM], `NCX_OP_SUB_SKIP_INSN_MEM, `NCX_OP_SUB_SKIP_INSN_XARP}
    |-> $stable(carry_out))
    else $error("skip op changed carry");
  a_bit_load: assert property (done_out && !skp_r && code_r == `NCX_OP_BIT_LD
    |-> carry_out == dq_r[pos_r])
    else $error("bit load carry wrong");
  a_bit_store: assert property (dmem_we_out |-> dmem_wdata_out[pos_r] == carry_out)
    else $error("bit store data wrong");
  a_store_keep: assert property (dmem_we_out |->
    ((dmem_wdata_out ^ dq_r) & ~(4'h1 << pos_r)) == 4'h0)
    else $error("bit store disturbed other bits");
  c_pcxa: cover property (done_out && code_r == `NCX_OP_TF_PCXA);
  c_skip: cover property (done_out && skp_r);
  c_store: cover property (dmem_we_out);
  c_adjust: cover property (done_out && code_r == `NCX_OP_ADD_CARRY_INSN_MEM && carry_out);
endmodule // ncx_monitor
bind ncx_exec_core ncx_monitor u_monitor (.sys_clk_in, .reset_n_in, .op_valid_in, .op_code_in,
  .op_pc_in, .bit_pos_in, .ready_out, .done_out, .skip_out, .carry_out, .regs_out,
  .pmem_addr_out, .pmem_rd_out, .pmem_data_in, .dmem_addr_out, .dmem_rd_out, .dmem_we_out,
  .dmem_wdata_out, .dmem_data_in);

// [tb_ncx_exec_core.sv]
/* Self-checking bench of the execution core with its memory model.
   Assumes the core, checker and memory model of this folder. */
`timescale 1ns/10ps
`include "ncx_consts.vh"
module tb_ncx_exec_core;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         vld = 1'b0;
  reg  [3:0]  code = 4'h0;
  reg  [2:0]  pair = 3'h0;
  reg  [7:0]  imm = 8'h00;
  reg  [15:0] pc = 16'h0000;
  reg  [7:0]  baddr = 8'h00;
  reg  [1:0]  bpos = 2'h0;
  reg  [15:0] e;
  wire        ready, done, skip, carry, prd, drd, dwe;
  wire [63:0] regs;
  wire [15:0] paddr;
  wire [7:0]  pdata, daddr;
  wire [3:0]  dwdata, ddata;
  integer     bad_count = 0;
  integer     num_checks = 0;
  always #12.5 clk = ~clk;
  ncx_exec_core dut (.sys_clk_in(clk), .reset_n_in(rst_n), .op_valid_in(vld),
    .op_code_in(code), .op_pair_in(pair), .op_imm_in(imm), .op_pc_in(pc), .bit_addr_in(baddr),
    .bit_pos_in(bpos), .ready_out(ready), .done_out(done), .skip_out(skip), .carry_out(carry),
    .regs_out(regs), .pmem_addr_out(paddr), .pmem_rd_out(prd), .pmem_data_in(pdata),
    .dmem_addr_out(daddr), .dmem_rd_out(drd), .dmem_we_out(dwe), .dmem_wdata_out(dwdata),
    .dmem_data_in(ddata));
  ncx_mem_model u_mem (.clk_in(clk), .paddr_in(paddr), .prd_in(prd), .pdata_out(pdata),
    .daddr_in(daddr), .drd_in(drd), .dwe_in(dwe), .dwdata_in(dwdata), .ddata_out(ddata));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task chk(input string nm, input [15:0] x, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  // Offers one operation and returns 1 ns into its done cycle.
  task op(input [3:0] c, input [2:0] p, input [7:0] im);
    integer n;
    begin
      @(posedge clk);
      code <= c;
      pair <= p;
      imm <= im;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      n = 0;
      #1;
      while (done !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("done seen", 16'h1, done);
    end
  endtask
  // Loads the acc pair; a carried load leaves a skip that is used up here.
  task setxa(input [7:0] v);
    begin
      op(`NCX_OP_ADDS_N8, 3'h0, v - regs[7:0]);
      if (skip === 1'b1)
        op(`NCX_OP_ADDS_N8, 3'h0, 8'h00);
    end
  endtask
  task setp(input [2:0] p, input [7:0] v);
    begin
      setxa(v - regs[8*p+:8]);
      op(`NCX_OP_ADDS_RPXA, p, 8'h00);
      if (skip === 1'b1)
        op(`NCX_OP_ADDS_N8, 3'h0, 8'h00);
    end
  endtask
  task bitop(input [3:0] c, input [7:0] a, input [1:0] p);
    begin
      @(posedge clk);
      baddr <= a;
      bpos <= p;
      op(c, 3'h0, 8'h00);
    end
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_table;
    begin
      setp(`NCX_PAIR_BC, 8'h05);
      setp(`NCX_PAIR_DE, 8'h34);
      @(posedge clk);
      pc <= 16'h1300;
      op(`NCX_OP_TF_PCDE, 3'h0, 8'h00);
      chk("pcde addr", 16'h1334, paddr);
      chk("pcde xa", u_mem.rom(16'h1334), regs[7:0]);
      e = {8'h13, u_mem.rom(16'h1334)};
      op(`NCX_OP_TF_PCXA, 3'h0, 8'h00);
      chk("pcxa addr", e, paddr);
      chk("pcxa xa", u_mem.rom(e), regs[7:0]);
      op(`NCX_OP_TF_BCDE, 3'h0, 8'h00);
      chk("bcde addr", 16'h0534, paddr);
      e = {8'h05, u_mem.rom(16'h0534)};
      op(`NCX_OP_TF_BCXA, 3'h0, 8'h00);
      chk("bcxa xa", u_mem.rom(e), regs[7:0]);
      $display("table test ended");
    end
  endtask
  task t_bits;
    begin
      bitop(`NCX_OP_BIT_LD, 8'h05, 2'h2);
      chk("load one", 16'h1, carry);
      bitop(`NCX_OP_BIT_LD, 8'h09, 2'h0);
      chk("load zero", 16'h0, carry);
      bitop(`NCX_OP_BIT_ST, 8'h0A, 2'h0);
      @(posedge clk);
      #1;
      chk("stored nibble", 16'h2, u_mem.ram[8'h0A]);
      bitop(`NCX_OP_BIT_LD, 8'h05, 2'h2);
      chk("reload one", 16'h1, carry);
      bitop(`NCX_OP_BIT_ST, 8'h0A, 2'h3);
      @(posedge clk);
      #1;
      chk("stored one", 16'hA, u_mem.ram[8'h0A]);
      $display("bit test ended");
    end
  endtask
  task t_adds;
    begin
      setxa(8'hF0);
      op(`NCX_OP_ADDS_N8, 3'h0, 8'h20);
      chk("n8 sum", 16'h10, regs[7:0]);
      chk("n8 skip", 16'h1, skip);
      chk("n8 carry", 16'h1, carry);
      op(`NCX_OP_ADDS_N8, 3'h0, 8'h01);
      chk("skipped op", 16'h10, regs[7:0]);
      op(`NCX_OP_ADDS_N4, 3'h0, 8'h0F);
      chk("n4 sum", 16'h1F, regs[7:0]);
      chk("n4 carry", 16'h1, carry);
      op(`NCX_OP_ADDS_N4, 3'h0, 8'h01);
      chk("n4 skip", 16'h1, skip);
      op(`NCX_OP_ADDS_N8, 3'h0, 8'h00);
      setp(`NCX_PAIR_HL, 8'hC0);
      setxa(8'h50);
      op(`NCX_OP_ADDS_XARP, `NCX_PAIR_HL, 8'h00);
      chk("pair skip", 16'h1, skip);
      op(`NCX_OP_ADDS_N8, 3'h0, 8'h00);
      op(`NCX_OP_ADDS_MEM, 3'h0, 8'h00);
      chk("mem sum", 16'h19, regs[7:0]);
      $display("skip add test ended");
    end
  endtask
  task t_carry_sub;
    begin
      op(`NCX_OP_ADD_CARRY_INSN_MEM, 3'h0, 8'h00);
      chk("add_carry_insn sum", 16'h13, regs[7:0]);
      op(`NCX_OP_ADDS_N4, 3'h0, 8'h06);
      chk("adjust skipped", 16'h13, regs[7:0]);
      op(`NCX_OP_ADD_CARRY_INSN_MEM, 3'h0, 8'h00);
      chk("add_carry_insn clear", 16'h0, carry);
      op(`NCX_OP_ADDS_N4, 3'h0, 8'h0A);
      chk("adjust sum", 16'h17, regs[7:0]);
      chk("adjust noskip", 16'h0, skip);
      op(`NCX_OP_ADD_CARRY_INSN_XARP, `NCX_PAIR_HL, 8'h00);
      op(`NCX_OP_ADD_CARRY_INSN_XARP, `NCX_PAIR_HL, 8'h00);
      chk("add_carry_insn pair", 16'h197, {carry, regs[7:0]});
      op(`NCX_OP_SUB_SKIP_INSN_MEM, 3'h0, 8'h00);
      chk("sub_skip_insn mem", 16'h19E, {skip, regs[7:0]});
      op(`NCX_OP_ADDS_N8, 3'h0, 8'h00);
      op(`NCX_OP_SUB_SKIP_INSN_XARP, `NCX_PAIR_HL, 8'h00);
      chk("sub_skip_insn pair", 16'h3DE, {skip, carry, regs[7:0]});
      op(`NCX_OP_ADDS_N8, 3'h0, 8'h00);
      op(`NCX_OP_ADD_CARRY_INSN_RPXA, 3'h5, 8'h00);
      chk("add_carry_insn other pair", 16'h0DF, {carry, regs[47:40]});
      chk("add_carry_insn keeps acc", 16'hDE, regs[7:0]);
      $display("carry and subtract test ended");
    end
  endtask
  // Mid-run reset: state returns to its reset values, and an op offered
  // right after reset is seen high must be taken.
  task t_reset;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset regs", 16'h0, {15'h0, |regs});
      chk("reset flags", 16'h2, {skip, carry, ready, done});
      chk("reset strobes", 16'h0, {prd, drd, dwe});
      op(`NCX_OP_ADDS_N8, 3'h0, 8'hA5);
      chk("first op", 16'h0A5, {skip, regs[7:0]});
      $display("reset test ended");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Reset for six cycles, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_table;
    t_bits;
    t_adds;
    t_carry_sub;
    t_reset;
    complete_run;
  end
  // Watchdog well beyond the hundred or so cycles the scenarios need.
  initial begin
    #200000;
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule // tb_ncx_exec_core
